// ### core/ums_pkg.sv
/*
 * Shared constants of the modem status, scratchpad and FIFO interrupt block:
 * register indices, field positions, reset values, identification codes.
 * Assumes a byte-wide CPU port with a three-bit register index.
 */
`default_nettype none
package ums_pkg;
    // Register indices on the CPU port
    localparam logic [2:0] UMS_A_DATA = 3'h0;
    localparam logic [2:0] UMS_A_IEN  = 3'h1;
    localparam logic [2:0] UMS_A_IID  = 3'h2;
    localparam logic [2:0] UMS_A_MCTL = 3'h4;
    localparam logic [2:0] UMS_A_LST  = 3'h5;
    localparam logic [2:0] UMS_A_MST  = 3'h6;
    localparam logic [2:0] UMS_A_SCR  = 3'h7;

    // Interrupt enable fields
    localparam int UMS_IEN_RDA = 0;
    localparam int UMS_IEN_THR = 1;
    localparam int UMS_IEN_RLS = 2;
    localparam int UMS_IEN_MST = 3;
    // FIFO control fields
    localparam int UMS_FCR_EN    = 0;
    localparam int UMS_FCR_RXRST = 1;
    localparam int UMS_FCR_TRIG  = 6;
    // Modem control fields
    localparam int UMS_MCR_DTR  = 0;
    localparam int UMS_MCR_RTS  = 1;
    localparam int UMS_MCR_USER_OUTPUT_ONE = 2;
    localparam int UMS_MCR_USER_OUTPUT_TWO = 3;
    localparam int UMS_MCR_LOOP = 4;
    // Modem status fields: change flags low, line levels high
    localparam int UMS_MST_CTS = 0;
    localparam int UMS_MST_DSR = 1;
    localparam int UMS_MST_RI  = 2;
    localparam int UMS_MST_DCD = 3;
    // Line status fields
    localparam int UMS_LST_DR   = 0;
    localparam int UMS_LST_ERR  = 1;
    localparam int UMS_LST_TRANSMIT_HOLDING_EMPTY = 5;
    localparam int UMS_LST_TEMT = 6;

    // Reset values
    localparam logic [7:0] UMS_RST_IEN  = 8'h00;
    localparam logic [7:0] UMS_RST_FCR  = 8'h00;
    localparam logic [7:0] UMS_RST_MCTL = 8'h00;
    localparam logic [7:0] UMS_RST_SCR  = 8'h00;

    // Identification codes, low nibble
    localparam logic [3:0] UMS_ID_NONE = 4'h1;
    localparam logic [3:0] UMS_ID_RLS  = 4'h6;
    localparam logic [3:0] UMS_ID_RDA  = 4'h4;
    localparam logic [3:0] UMS_ID_CTO  = 4'hc;
    localparam logic [3:0] UMS_ID_THR  = 4'h2;
    localparam logic [3:0] UMS_ID_MST  = 4'h0;

    // Timeout length in character times
    localparam logic [7:0] UMS_TO_CHARS = 8'h04;
    // Receive trigger levels, selected by the two trigger bits
    localparam logic [4:0] UMS_TRIG_L0 = 5'h01;
    localparam logic [4:0] UMS_TRIG_L1 = 5'h04;
    localparam logic [4:0] UMS_TRIG_L2 = 5'h08;
    localparam logic [4:0] UMS_TRIG_L3 = 5'h0e;

    typedef enum logic [2:0] {
        UMS_THR_BUSY  = 3'b001,
        UMS_THR_DELAY = 3'b010,
        UMS_THR_EMPTY = 3'b100
    } ums_thr_st_t;
endpackage
`default_nettype wire

// ### core/ums_sync.sv
/*
 * Two-flop synchroniser for a bundle of level inputs.
 * Assumes each bit is slow compared with the clock; no bus coherency.
 */
`timescale 1ns/100ps
`default_nettype none
module ums_sync #(
    parameter int         W   = 4,
    parameter logic [3:0] RST = 4'hf
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s1_r <= RST[W-1:0];
            s2_r <= RST[W-1:0];
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end

    assign q = s2_r;
endmodule
`default_nettype wire

// ### core/ums_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides, a fill count and flush.
 * Assumes DEPTH is a power of two.
 */
`timescale 1ns/100ps
`default_nettype none
module ums_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic      [AW:0]      count
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];
    assign count     = cnt_r;
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;

    always_comb begin
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (flush) begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = '0;
        end else begin
            if (push)
                wp_nxt = wp_r + 1'b1;
            if (pop)
                rp_nxt = rp_r + 1'b1;
            if (push && !pop)
                cnt_nxt = cnt_r + 1'b1;
            else if (pop && !push)
                cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset
    always_ff @(posedge ref_clk) begin
        if (push)
            mem[wp_r] <= in_data;
    end
endmodule
`default_nettype wire

// ### core/ums_core.sv
/*
 * Modem status with change flags, scratchpad, receive FIFO with trigger
 * and character timeout, transmit-empty interrupt, and interrupt priority.
 * Assumes a byte CPU port with one-cycle read/write strobes, a receiver
 * that pushes characters with valid/ready, one rclk_tick per bit time, and
 * an outside transmit FIFO that reports its fill.
 */
`timescale 1ns/100ps
`default_nettype none
module ums_core
    import ums_pkg::*;
#(
    parameter int DW    = 8,
    parameter int DEPTH = 16
) (
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    input  wire logic          cpu_rd,
    input  wire logic          cpu_wr,
    input  wire logic [2:0]    cpu_addr,
    input  wire logic [DW-1:0] cpu_wdata,
    output logic      [DW-1:0] cpu_rdata,
    input  wire logic          clear_to_send_n,
    input  wire logic          data_set_ready_n,
    input  wire logic          ring_indicator_n,
    input  wire logic          carrier_detect_n,
    output logic               terminal_ready_n,
    output logic               request_to_send_n,
    input  wire logic          rx_char_valid,
    output logic               rx_char_ready,
    input  wire logic [DW-1:0] rx_char_data,
    input  wire logic          rx_line_event,
    input  wire logic          rclk_tick,
    input  wire logic [3:0]    char_bits,
    input  wire logic [4:0]    tx_fifo_count,
    output logic               tx_wr,
    output logic      [DW-1:0] tx_wr_data,
    output logic               loopback,
    output logic               uart_irq
);
    import ums_pkg::*;

    logic [7:0]  ien_r, ien_nxt, fcr_r, fcr_nxt;
    logic [7:0]  mcr_r, mcr_nxt, scr_r, scr_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic [3:0]  mflag_r, mflag_nxt, prev_r;
    logic        prime_r, rls_r, rls_nxt;
    logic [7:0]  to_cnt_r, to_cnt_nxt;
    logic        cto_r, cto_nxt;
    logic        thr_pend_r, thr_pend_nxt, two_seen_r, two_seen_nxt;
    logic        imm_r, imm_nxt, txw_r;
    logic [3:0]  dly_r, dly_nxt;
    ums_thr_st_t thr_st_r, thr_st_nxt;
    logic [DW-1:0] txd_r;

    logic [3:0]    modem_n, sync_n, src, mevt;
    logic [7:0]    mst_val, lst_val, iid_val;
    logic [3:0]    iid_code;
    logic          fifo_en, rd_data, rd_mst, rd_iid, rd_lst, wr_thr, wr_fcr;
    logic          flush, fifo_out_valid, fifo_in_ready, rda_pend;
    logic          rls_int, rda_int, cto_int, thr_int, mst_int;
    logic [4:0]    fill, trig;
    logic [7:0]    to_limit;
    logic [DW-1:0] fifo_head;

    assign fifo_en = fcr_r[UMS_FCR_EN];
    assign rd_data = cpu_rd && cpu_addr == UMS_A_DATA;
    assign rd_iid  = cpu_rd && cpu_addr == UMS_A_IID;
    assign rd_lst  = cpu_rd && cpu_addr == UMS_A_LST;
    assign rd_mst  = cpu_rd && cpu_addr == UMS_A_MST;
    assign wr_thr  = cpu_wr && cpu_addr == UMS_A_DATA;
    assign wr_fcr  = cpu_wr && cpu_addr == UMS_A_IID;
    // Receive FIFO is flushed on request or when FIFO mode toggles
    assign flush   = wr_fcr && (cpu_wdata[UMS_FCR_RXRST]
                     || cpu_wdata[UMS_FCR_EN] != fifo_en);

    // Modem inputs pass two flops before any edge logic
    assign modem_n = {carrier_detect_n, ring_indicator_n,
                      data_set_ready_n, clear_to_send_n};
    ums_sync #(.W(4), .RST(4'hf)) u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .d       (modem_n),
        .q       (sync_n)
    );

    // Asserted levels; loopback feeds control bits back
    assign loopback = mcr_r[UMS_MCR_LOOP];
    assign src = loopback ? {mcr_r[UMS_MCR_USER_OUTPUT_TWO], mcr_r[UMS_MCR_USER_OUTPUT_ONE],
                             mcr_r[UMS_MCR_DTR], mcr_r[UMS_MCR_RTS]}
                          : ~sync_n;
    // Trailing ring edge is ring_n rising, asserted level falling
    assign mevt = prime_r ? {src[3] ^ prev_r[3], prev_r[2] & ~src[2],
                             src[1] ^ prev_r[1], src[0] ^ prev_r[0]}
                          : 4'h0;
    assign mst_val = {src, mflag_r};
    assign terminal_ready_n  = loopback | ~mcr_r[UMS_MCR_DTR];
    assign request_to_send_n = loopback | ~mcr_r[UMS_MCR_RTS];

    // Receive path, one word deep outside FIFO mode
    ums_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_rxf (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .flush     (flush),
        .in_valid  (rx_char_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_char_data),
        .out_valid (fifo_out_valid),
        .out_ready (rd_data),
        .out_data  (fifo_head),
        .count     (fill)
    );
    assign rx_char_ready = fifo_in_ready && (fifo_en || fill == 5'h00);

    always_comb begin
        case (fcr_r[UMS_FCR_TRIG +: 2])
            2'h0:    trig = UMS_TRIG_L0;
            2'h1:    trig = UMS_TRIG_L1;
            2'h2:    trig = UMS_TRIG_L2;
            default: trig = UMS_TRIG_L3;
        endcase
    end
    assign rda_pend = fifo_en ? (fill >= trig) : fifo_out_valid;
    assign to_limit = UMS_TO_CHARS * {4'h0, char_bits};

    // Sources gated by their enables; polled mode is all enables off
    assign rls_int = rls_r && ien_r[UMS_IEN_RLS];
    assign rda_int = rda_pend && ien_r[UMS_IEN_RDA];
    assign cto_int = cto_r && ien_r[UMS_IEN_RDA];
    assign thr_int = thr_pend_r && ien_r[UMS_IEN_THR];
    assign mst_int = (mflag_r != 4'h0) && ien_r[UMS_IEN_MST];

    // Fixed priority: line status, received data/timeout, empty, modem
    always_comb begin
        if (rls_int)
            iid_code = UMS_ID_RLS;
        else if (rda_int)
            iid_code = UMS_ID_RDA;
        else if (cto_int)
            iid_code = UMS_ID_CTO;
        else if (thr_int)
            iid_code = UMS_ID_THR;
        else if (mst_int)
            iid_code = UMS_ID_MST;
        else
            iid_code = UMS_ID_NONE;
    end
    assign iid_val  = {fifo_en, fifo_en, 2'b00, iid_code};
    assign uart_irq = (iid_code != UMS_ID_NONE);
    assign lst_val  = {1'b0, tx_fifo_count == 5'h00,
                       thr_st_r == UMS_THR_EMPTY, 3'b000, rls_r,
                       fifo_out_valid};

    // Register writes, flags and read data
    always_comb begin
        ien_nxt   = ien_r;
        fcr_nxt   = fcr_r;
        mcr_nxt   = mcr_r;
        scr_nxt   = scr_r;
        rdata_nxt = rdata_r;
        if (cpu_wr) begin
            case (cpu_addr)
                UMS_A_IEN:  ien_nxt = {4'h0, cpu_wdata[3:0]};
                UMS_A_IID:  fcr_nxt = {cpu_wdata[7:6], 5'h00,
                                       cpu_wdata[UMS_FCR_EN]};
                UMS_A_MCTL: mcr_nxt = {3'h0, cpu_wdata[4:0]};
                UMS_A_SCR:  scr_nxt = cpu_wdata;
                default:    ;
            endcase
        end
        if (cpu_rd) begin
            case (cpu_addr)
                UMS_A_DATA: rdata_nxt = fifo_out_valid ? fifo_head : 8'h00;
                UMS_A_IEN:  rdata_nxt = ien_r;
                UMS_A_IID:  rdata_nxt = iid_val;
                UMS_A_MCTL: rdata_nxt = mcr_r;
                UMS_A_LST:  rdata_nxt = lst_val;
                UMS_A_MST:  rdata_nxt = mst_val;
                UMS_A_SCR:  rdata_nxt = scr_r;
                default:    rdata_nxt = 8'h00;
            endcase
        end
        // A new event wins over the clear of the same cycle
        mflag_nxt = (rd_mst ? 4'h0 : mflag_r) | mevt;
        rls_nxt   = (rd_lst ? 1'b0 : rls_r) | rx_line_event;
    end

    // Character timeout timer
    always_comb begin
        to_cnt_nxt = to_cnt_r;
        cto_nxt    = cto_r;
        if (!fifo_en || !fifo_out_valid || flush) begin
            to_cnt_nxt = 8'h00;
            cto_nxt    = 1'b0;
        end else if (cto_r) begin
            if (rd_data) begin
                to_cnt_nxt = 8'h00;
                cto_nxt    = 1'b0;
            end
        end else if (rd_data || (rx_char_valid && rx_char_ready)) begin
            to_cnt_nxt = 8'h00;
        end else if (to_cnt_r >= to_limit) begin
            cto_nxt = 1'b1;
        end else if (rclk_tick) begin
            to_cnt_nxt = to_cnt_r + 8'h01;
        end
    end

    // Transmit-empty tracking with single-byte delay
    always_comb begin
        thr_st_nxt   = thr_st_r;
        dly_nxt      = dly_r;
        imm_nxt      = imm_r | (wr_fcr && cpu_wdata[UMS_FCR_EN] != fifo_en);
        two_seen_nxt = two_seen_r | (tx_fifo_count >= 5'h02);
        thr_pend_nxt = thr_pend_r;
        if (wr_thr || (rd_iid && iid_code == UMS_ID_THR))
            thr_pend_nxt = 1'b0;
        case (thr_st_r)
            UMS_THR_BUSY: begin
                if (tx_fifo_count == 5'h00) begin
                    if (imm_r || two_seen_r) begin
                        thr_st_nxt   = UMS_THR_EMPTY;
                        thr_pend_nxt = 1'b1;
                        imm_nxt      = 1'b0;
                    end else begin
                        thr_st_nxt = UMS_THR_DELAY;
                        dly_nxt    = char_bits - 4'h1;
                    end
                end
            end
            UMS_THR_DELAY: begin
                if (tx_fifo_count != 5'h00) begin
                    thr_st_nxt = UMS_THR_BUSY;
                end else if (dly_r == 4'h0 || imm_r) begin
                    thr_st_nxt   = UMS_THR_EMPTY;
                    thr_pend_nxt = 1'b1;
                    imm_nxt      = 1'b0;
                end else if (rclk_tick) begin
                    dly_nxt = dly_r - 4'h1;
                end
            end
            UMS_THR_EMPTY: begin
                two_seen_nxt = 1'b0;
                if (tx_fifo_count != 5'h00)
                    thr_st_nxt = UMS_THR_BUSY;
            end
            default: thr_st_nxt = UMS_THR_BUSY;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ien_r      <= UMS_RST_IEN;
            fcr_r      <= UMS_RST_FCR;
            mcr_r      <= UMS_RST_MCTL;
            scr_r      <= UMS_RST_SCR;
            rdata_r    <= 8'h00;
            mflag_r    <= 4'h0;
            prev_r     <= 4'h0;
            prime_r    <= 1'b0;
            rls_r      <= 1'b0;
            to_cnt_r   <= 8'h00;
            cto_r      <= 1'b0;
            thr_st_r   <= UMS_THR_EMPTY;
            thr_pend_r <= 1'b0;
            two_seen_r <= 1'b0;
            imm_r      <= 1'b1;
            dly_r      <= 4'h0;
            txw_r      <= 1'b0;
            txd_r      <= '0;
        end else begin
            ien_r      <= ien_nxt;
            fcr_r      <= fcr_nxt;
            mcr_r      <= mcr_nxt;
            scr_r      <= scr_nxt;
            rdata_r    <= rdata_nxt;
            mflag_r    <= mflag_nxt;
            prev_r     <= src;
            prime_r    <= 1'b1;
            rls_r      <= rls_nxt;
            to_cnt_r   <= to_cnt_nxt;
            cto_r      <= cto_nxt;
            thr_st_r   <= thr_st_nxt;
            thr_pend_r <= thr_pend_nxt;
            two_seen_r <= two_seen_nxt;
            imm_r      <= imm_nxt;
            dly_r      <= dly_nxt;
            txw_r      <= wr_thr;
            txd_r      <= wr_thr ? cpu_wdata : txd_r;
        end
    end

    assign cpu_rdata  = rdata_r;
    assign tx_wr      = txw_r;
    assign tx_wr_data = txd_r;

    a_cts_change_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
        (prime_r && src[0] != prev_r[0]) |=> mflag_r[0])
        else $error("cts change did not set its flag");
    a_mst_read_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rd_mst && mevt == 4'h0) |=> mflag_r == 4'h0)
        else $error("modem status read left a flag set");
    a_ring_edge_only: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!mflag_r[2] && !(prev_r[2] && !src[2])) |=> !mflag_r[2])
        else $error("ring flag set without trailing edge");
    a_mst_irq_raise: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mflag_r != 4'h0 && ien_r[UMS_IEN_MST]) |-> uart_irq)
        else $error("modem flag without interrupt");
    a_loop_mirror: assert property (@(posedge ref_clk) disable iff (!nrst)
        loopback |-> mst_val[7:4] == {mcr_r[3], mcr_r[2], mcr_r[0],
                                      mcr_r[1]})
        else $error("loopback status bits wrong");
    a_scratch_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cpu_wr && cpu_addr == UMS_A_SCR) ##1 (cpu_rd && cpu_addr == UMS_A_SCR
        && !cpu_wr) |=> cpu_rdata == $past(cpu_wdata, 2))
        else $error("scratchpad lost its value");
    a_rda_trigger: assert property (@(posedge ref_clk) disable iff (!nrst)
        (fifo_en && ien_r[UMS_IEN_RDA] && fill >= trig && !rls_int)
        |-> iid_code == UMS_ID_RDA)
        else $error("trigger level not reported");
    a_rls_first: assert property (@(posedge ref_clk) disable iff (!nrst)
        rls_int |-> iid_val[3:0] == UMS_ID_RLS)
        else $error("line status not highest");
    a_dr_follows_fill: assert property (@(posedge ref_clk) disable iff (!nrst)
        lst_val[UMS_LST_DR] == (fill != 5'h00))
        else $error("data ready disagrees with fill");
    a_timeout_fire: assert property (@(posedge ref_clk) disable iff (!nrst)
        (fifo_en && fifo_out_valid && !cto_r && to_cnt_r >= to_limit
         && !rd_data && !rx_char_valid && !flush) |=> cto_r)
        else $error("timeout did not fire");
    a_timeout_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cto_r && rd_data) |=> !cto_r && to_cnt_r == 8'h00)
        else $error("read did not clear timeout");
    a_thr_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_thr && (thr_st_r == UMS_THR_EMPTY || thr_st_nxt != UMS_THR_EMPTY))
        |=> !thr_pend_r)
        else $error("holding write did not clear empty interrupt");
endmodule
`default_nettype wire

// ### verif/ums_peer.sv
/* Modem peer: drives the four active-low modem lines.
   Assumes want bits 0..3 = cts, dsr, ring, carrier asserted. */
`timescale 1ns/100ps
`default_nettype none
module ums_peer (
    input  wire logic       ref_clk,
    input  wire logic [3:0] want,
    output logic      [3:0] line_n
);
    initial line_n = 4'hf;
    // Lines follow one edge after the request, like a slow peer
    always @(posedge ref_clk) begin
        line_n <= ~want;
    end
endmodule
`default_nettype wire

// ### verif/ums_core_tb_top.sv
/* Bench for ums_core: modem flags, loopback, scratchpad, receive trigger
   and timeout. Assumes ums_peer drives the modem lines. */
`timescale 1ns/100ps
`default_nettype none
module ums_core_tb_top;
    import ums_pkg::*;
    logic       ref_clk = 1'h0, nrst = 1'h0, cpu_rd = 1'h0, cpu_wr = 1'h0;
    logic       rx_char_valid = 1'h0, rclk_tick = 1'h0, uart_irq, dtr_n;
    logic [2:0] cpu_addr = 3'h0;
    logic [7:0] cpu_wdata = 8'h00, rx_char_data = 8'h00, cpu_rdata, d, txd;
    logic [4:0] txc = 5'h00;
    logic       lev = 1'h0, rdy, rts_n, lpb, tx_wr;
    logic [3:0] want = 4'h0;
    wire  logic [3:0] line_n;
    int         err_total = 0, checks_done = 0;
    initial forever #25 ref_clk = ~ref_clk;
    ums_peer u_peer (.ref_clk(ref_clk), .want(want), .line_n(line_n));
    ums_core u_dut (.ref_clk(ref_clk), .nrst(nrst), .cpu_rd(cpu_rd),
        .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .clear_to_send_n(line_n[0]),
        .data_set_ready_n(line_n[1]), .ring_indicator_n(line_n[2]),
        .carrier_detect_n(line_n[3]), .terminal_ready_n(dtr_n),
        .request_to_send_n(rts_n), .rx_char_valid(rx_char_valid),
        .rx_char_ready(rdy), .rx_char_data(rx_char_data),
        .rx_line_event(lev), .rclk_tick(rclk_tick), .char_bits(4'ha),
        .tx_fifo_count(txc), .tx_wr(tx_wr), .tx_wr_data(txd),
        .loopback(lpb), .uart_irq(uart_irq));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wrap_up;
        if (err_total == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One access; read data lands in d
    task automatic acc(input logic w, input logic [2:0] a,
                       input logic [7:0] v);
        @(posedge ref_clk);
        cpu_wr <= w;
        cpu_rd <= ~w;
        cpu_addr <= a;
        cpu_wdata <= v;
        @(posedge ref_clk);
        cpu_wr <= 1'h0;
        cpu_rd <= 1'h0;
        @(negedge ref_clk);
        d = cpu_rdata;
    endtask
    task automatic lines(input logic [3:0] v);
        @(posedge ref_clk);
        want <= v;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic push(input logic [7:0] v);
        @(posedge ref_clk);
        rx_char_valid <= 1'h1;
        rx_char_data <= v;
        @(posedge ref_clk);
        rx_char_valid <= 1'h0;
        @(negedge ref_clk);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            rclk_tick <= 1'h1;
            @(posedge ref_clk);
            rclk_tick <= 1'h0;
        end
        @(negedge ref_clk);
    endtask
    task automatic t_scratch;
        acc(1'h0, UMS_A_SCR, 8'h00);
        chk(d, 8'h00);
        acc(1'h1, UMS_A_SCR, 8'h5a);
        acc(1'h0, UMS_A_SCR, 8'h00);
        chk(d, 8'h5a);
        // Write then read on back-to-back cycles
        @(posedge ref_clk);
        cpu_wr <= 1'h1;
        cpu_addr <= UMS_A_SCR;
        cpu_wdata <= 8'hc3;
        @(posedge ref_clk);
        cpu_wr <= 1'h0;
        cpu_rd <= 1'h1;
        @(posedge ref_clk);
        cpu_rd <= 1'h0;
        @(negedge ref_clk);
        chk(cpu_rdata, 8'hc3);
    endtask
    task automatic t_modem;
        acc(1'h1, UMS_A_IEN, 8'h08);
        lines(4'h1);
        chk({7'h0, uart_irq}, 8'h01);
        acc(1'h0, UMS_A_MST, 8'h00);
        chk(d, 8'h11);
        acc(1'h0, UMS_A_MST, 8'h00);
        chk(d, 8'h10);
        chk({7'h0, uart_irq}, 8'h00);
        lines(4'h5);
        acc(1'h0, UMS_A_MST, 8'h00);
        chk(d, 8'h50);
        acc(1'h1, UMS_A_IEN, 8'h00);
        lines(4'h1);
        chk({7'h0, uart_irq}, 8'h00);
        acc(1'h0, UMS_A_MST, 8'h00);
        chk(d, 8'h14);
        lines(4'hb);
        acc(1'h0, UMS_A_MST, 8'h00);
        chk(d, 8'hba);
    endtask
    task automatic t_loop;
        acc(1'h1, UMS_A_MCTL, 8'h13);
        acc(1'h0, UMS_A_MST, 8'h00);
        chk(d & 8'hf0, 8'h30);
        chk({5'h0, lpb, rts_n, dtr_n}, 8'h07);
        acc(1'h1, UMS_A_MCTL, 8'h03);
        chk({5'h0, lpb, rts_n, dtr_n}, 8'h00);
        repeat (4) @(posedge ref_clk);
        acc(1'h0, UMS_A_MST, 8'h00);
        chk(d & 8'hf0, 8'hb0);
    endtask
    task automatic t_rx;
        push(8'h77);
        chk({7'h0, rdy}, 8'h00);
        acc(1'h1, UMS_A_IID, 8'h41);
        acc(1'h1, UMS_A_IEN, 8'h01);
        for (int i = 0; i < 3; i++) push(8'ha0 + i[7:0]);
        chk({7'h0, uart_irq}, 8'h00);
        push(8'ha3);
        chk({7'h0, uart_irq}, 8'h01);
        acc(1'h0, UMS_A_IID, 8'h00);
        chk(d, 8'hc4);
        acc(1'h1, UMS_A_IEN, 8'h05);
        @(posedge ref_clk);
        lev <= 1'h1;
        @(posedge ref_clk);
        lev <= 1'h0;
        acc(1'h0, UMS_A_IID, 8'h00);
        chk(d, 8'hc6);
        acc(1'h0, UMS_A_LST, 8'h00);
        chk(d & 8'h03, 8'h03);
        acc(1'h1, UMS_A_IEN, 8'h01);
        acc(1'h0, UMS_A_DATA, 8'h00);
        chk(d, 8'ha0);
        chk({7'h0, uart_irq}, 8'h00);
        ticks(38);
        chk({7'h0, uart_irq}, 8'h00);
        for (int i = 0; i < 10 && uart_irq !== 1'h1; i++) ticks(1);
        if (uart_irq !== 1'h1) begin
            err_total++;
            wrap_up;
        end
        acc(1'h0, UMS_A_IID, 8'h00);
        chk(d, 8'hcc);
        acc(1'h0, UMS_A_DATA, 8'h00);
        chk({7'h0, uart_irq}, 8'h00);
        acc(1'h1, UMS_A_IEN, 8'h00);
        acc(1'h0, UMS_A_LST, 8'h00);
        chk(d & 8'h01, 8'h01);
        acc(1'h0, UMS_A_DATA, 8'h00);
        acc(1'h0, UMS_A_DATA, 8'h00);
        chk(d, 8'ha3);
        acc(1'h0, UMS_A_LST, 8'h00);
        chk(d & 8'h01, 8'h00);
    endtask
    task automatic t_tx;
        acc(1'h1, UMS_A_IEN, 8'h02);
        @(posedge ref_clk);
        txc <= 5'h01;
        @(posedge ref_clk);
        txc <= 5'h00;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({7'h0, uart_irq}, 8'h01);
        acc(1'h0, UMS_A_IID, 8'h00);
        chk(d, 8'hc2);
        chk({7'h0, uart_irq}, 8'h00);
        // Single byte since last empty: indication waits char_bits-1 ticks
        @(posedge ref_clk);
        txc <= 5'h01;
        @(posedge ref_clk);
        txc <= 5'h00;
        ticks(8);
        chk({7'h0, uart_irq}, 8'h00);
        ticks(2);
        chk({7'h0, uart_irq}, 8'h01);
        acc(1'h1, UMS_A_DATA, 8'h3c);
        chk({7'h0, uart_irq}, 8'h00);
        chk({7'h0, tx_wr}, 8'h01);
        chk(txd, 8'h3c);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'h1;
        t_scratch;
        t_modem;
        t_loop;
        t_rx;
        t_tx;
        wrap_up;
    end
endmodule
`default_nettype wire
